/* design/adcc_top.sv */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adcc_params.svh"
module adcc_top (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [11:0]   awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [11:0]   araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic [6:0]    trig_in,
  input  wire logic          global_irq_en,
  input  wire logic          irq_vector_ack,
  input  wire logic [9:0]    core_result,
  output adcc_pkg::adcc_core_s core_ctl,
  output logic               irq_req
);

  adcc_pkg::adcc_ctrl_s  ctrl_r;
  adcc_pkg::adcc_state_e state_r;
  logic        flag_r;
  logic [5:0]  mux_r;
  logic [4:0]  applied_ch_r;
  logic [2:0]  trig_sel_r;
  logic [9:0]  result_r;
  logic        lock_r;
  logic        init_needed_r;
  logic [4:0]  cnt_r;
  logic        start_r;
  logic        aw_have_r;
  logic [11:0] aw_addr_r;
  logic        w_have_r;
  logic [7:0]  w_data_r;
  logic        w_lane_r;
  logic [6:0]  trig_s1_r;
  logic [6:0]  trig_s2_r;
  logic        trig_prev_r;
  logic        div_tick;
  logic        busy;
  logic        wr_fire;
  logic        wr_ctrl;
  logic        ar_fire;
  logic        rd_lo;
  logic        rd_hi;
  logic        en_nxt;
  logic        abort;
  logic        go;
  logic        done_evt;
  logic        free_restart;
  logic        trig_lvl;
  logic        trig_edge;
  logic [4:0]  last_cnt;
  logic [15:0] pres;
  logic [7:0]  rd_byte;
  logic [7:0]  wd;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [7:0]  idx);
    addr_is = (a[11:2] == {2'b00, idx});
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = addr_is(a, `ADCC_IDX_RES_LO) ||
                  addr_is(a, `ADCC_IDX_RES_HI) ||
                  addr_is(a, `ADCC_IDX_CTRL)   ||
                  addr_is(a, `ADCC_IDX_TRIG)   ||
                  addr_is(a, `ADCC_IDX_MUX);
  endfunction : addr_mapped

  // Write channel: address and data taken in either order
  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign wr_fire = aw_have_r && w_have_r && !bvalid;
  assign wd      = w_data_r;
  // Registers are one byte wide; only lane 0 can change them
  assign wr_ctrl = wr_fire && w_lane_r &&
                   addr_is(aw_addr_r, `ADCC_IDX_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end else if (awvalid && awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_have_r <= 1'b1;
      w_data_r <= wdata[7:0];
      w_lane_r <= wstrb[0];
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `ADCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= addr_mapped(aw_addr_r) ? `ADCC_RESP_OKAY
                                       : `ADCC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel
  assign arready = !rvalid;
  assign ar_fire = arvalid && arready;
  assign rd_lo   = ar_fire && addr_is(araddr, `ADCC_IDX_RES_LO);
  assign rd_hi   = ar_fire && addr_is(araddr, `ADCC_IDX_RES_HI);
  assign busy    = (state_r != adcc_pkg::ADCC_IDLE);

  // Alignment is applied on read, so a change shows at once
  assign pres = mux_r[`ADCC_BIT_LADJ] ? {result_r, 6'h00}
                                      : {6'h00, result_r};

  always_comb begin
    rd_byte = 8'h00;
    if (addr_is(araddr, `ADCC_IDX_RES_LO)) begin
      rd_byte = pres[7:0];
    end else if (addr_is(araddr, `ADCC_IDX_RES_HI)) begin
      rd_byte = pres[15:8];
    end else if (addr_is(araddr, `ADCC_IDX_CTRL)) begin
      rd_byte = {ctrl_r.en, busy, ctrl_r.ate, flag_r,
                 ctrl_r.ie, ctrl_r.div};
    end else if (addr_is(araddr, `ADCC_IDX_TRIG)) begin
      rd_byte = {5'h00, trig_sel_r};
    end else if (addr_is(araddr, `ADCC_IDX_MUX)) begin
      rd_byte = {2'b00, mux_r};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `ADCC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_byte};
      rresp  <= addr_mapped(araddr) ? `ADCC_RESP_OKAY
                                    : `ADCC_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Result lock between low and high byte reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_r <= 1'b0;
    end else if (rd_lo) begin
      lock_r <= 1'b1;
    end else if (rd_hi) begin
      lock_r <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 6'(`ADCC_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_r.en  <= wd[`ADCC_BIT_EN];
      ctrl_r.ate <= wd[`ADCC_BIT_ATE];
      ctrl_r.ie  <= wd[`ADCC_BIT_IE];
      ctrl_r.div <= wd[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_r <= `ADCC_MUX_RST;
    end else if (wr_fire && w_lane_r &&
                 addr_is(aw_addr_r, `ADCC_IDX_MUX)) begin
      mux_r <= wd[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sel_r <= `ADCC_TRIG_RST;
    end else if (wr_fire && w_lane_r &&
                 addr_is(aw_addr_r, `ADCC_IDX_TRIG)) begin
      trig_sel_r <= wd[2:0];
    end
  end

  // Trigger inputs arrive from other logic and pins
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          trig_s1_r[gi] <= 1'b0;
          trig_s2_r[gi] <= 1'b0;
        end else begin
          trig_s1_r[gi] <= trig_in[gi];
          trig_s2_r[gi] <= trig_s1_r[gi];
        end
      end
    end
  endgenerate

  // Changing source may itself make an edge; this is intended
  assign trig_lvl  = (trig_sel_r == `ADCC_TRIG_FREE) ? 1'b0
                     : trig_s2_r[trig_sel_r - 3'h1];
  assign trig_edge = trig_lvl && !trig_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_lvl;
    end
  end

  // Conversion sequencing
  assign en_nxt   = wr_ctrl ? wd[`ADCC_BIT_EN] : ctrl_r.en;
  assign abort    = wr_ctrl && !wd[`ADCC_BIT_EN];
  assign go       = !busy && en_nxt &&
                    ((wr_ctrl && wd[`ADCC_BIT_SC]) ||
                     (ctrl_r.ate && trig_edge));
  assign last_cnt = (state_r == adcc_pkg::ADCC_INIT)
                    ? `ADCC_FIRST_CYC - 5'h01
                    : `ADCC_NORMAL_CYC - 5'h01;
  assign done_evt = busy && div_tick && (cnt_r == last_cnt) && !abort;
  // Free running restarts from completion only, so selecting it
  // with the flag already set starts nothing
  assign free_restart = done_evt && ctrl_r.ate &&
                        (trig_sel_r == `ADCC_TRIG_FREE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_needed_r <= 1'b1;
    end else if (go) begin
      init_needed_r <= 1'b0;
    end else if (!ctrl_r.en) begin
      init_needed_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= adcc_pkg::ADCC_IDLE;
      cnt_r   <= 5'h00;
    end else if (abort) begin
      state_r <= adcc_pkg::ADCC_IDLE;
      cnt_r   <= 5'h00;
    end else begin
      case (state_r)
        adcc_pkg::ADCC_IDLE: begin
          cnt_r <= 5'h00;
          if (go) begin
            state_r <= init_needed_r ? adcc_pkg::ADCC_INIT
                                     : adcc_pkg::ADCC_CONV;
          end
        end
        adcc_pkg::ADCC_INIT, adcc_pkg::ADCC_CONV: begin
          if (free_restart) begin
            state_r <= adcc_pkg::ADCC_CONV;
            cnt_r   <= 5'h00;
          end else if (done_evt) begin
            state_r <= adcc_pkg::ADCC_IDLE;
            cnt_r   <= 5'h00;
          end else if (div_tick) begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= adcc_pkg::ADCC_IDLE;
          cnt_r   <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
    end else begin
      start_r <= (go && !abort) || free_restart;
    end
  end

  // Channel seen by the core only moves between conversions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_ch_r <= 5'h00;
    end else if (!busy || done_evt) begin
      applied_ch_r <= mux_r[4:0];
    end
  end

  // A locked result is kept; the new sample is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 10'h000;
    end else if (done_evt && !lock_r) begin
      result_r <= core_result;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (done_evt) begin
      flag_r <= 1'b1;
    end else if ((wr_ctrl && wd[`ADCC_BIT_IF]) || irq_vector_ack) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= flag_r && ctrl_r.ie && global_irq_en;
    end
  end

  adcc_clkdiv u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (ctrl_r.en),
    .sel     (ctrl_r.div),
    .tick    (div_tick)
  );

  assign core_ctl = '{start:   start_r,
                      enable:  ctrl_r.en,
                      clk_en:  div_tick,
                      channel: applied_ch_r};

endmodule : adcc_top

/* shared/adcc_params.svh */
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

`define ADCC_IDX_RES_LO   8'h78
`define ADCC_IDX_RES_HI   8'h79
`define ADCC_IDX_CTRL     8'h7A
`define ADCC_IDX_TRIG     8'h7B
`define ADCC_IDX_MUX      8'h7C

`define ADCC_BIT_EN       7
`define ADCC_BIT_SC       6
`define ADCC_BIT_ATE      5
`define ADCC_BIT_IF       4
`define ADCC_BIT_IE       3
`define ADCC_BIT_LADJ     5

`define ADCC_CTRL_RST     8'h00
`define ADCC_MUX_RST      6'h00
`define ADCC_TRIG_RST     3'h0
`define ADCC_TRIG_FREE    3'h0

// Converter clock cycles per conversion: 25 first, 13 normal
`define ADCC_FIRST_CYC    5'h19
`define ADCC_NORMAL_CYC   5'h0D

`define ADCC_RESP_OKAY    2'h0
`define ADCC_RESP_SLVERR  2'h2

`endif

/* shared/adcc_pkg.sv */
package adcc_pkg;

  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_INIT = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_e;

  typedef struct packed {
    logic       en;
    logic       ate;
    logic       ie;
    logic [2:0] div;
  } adcc_ctrl_s;

  typedef struct packed {
    logic       start;
    logic       enable;
    logic       clk_en;
    logic [4:0] channel;
  } adcc_core_s;

endpackage : adcc_pkg

/* design/adcc_clkdiv.sv */
`timescale 1ns/1ps
module adcc_clkdiv (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [6:0] cnt_r;
  logic [6:0] last;

  function automatic logic [6:0] div_last(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: div_last = 7'h01;
      3'h2:       div_last = 7'h03;
      3'h3:       div_last = 7'h07;
      3'h4:       div_last = 7'h0F;
      3'h5:       div_last = 7'h1F;
      3'h6:       div_last = 7'h3F;
      default:    div_last = 7'h7F;
    endcase
  endfunction : div_last

  assign last = div_last(sel);

  // Held at zero while off so the first tick is a full period
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || cnt_r >= last) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_r >= last);
    end
  end

endmodule : adcc_clkdiv

/* test/adcc_properties.sv */
`timescale 1ns/1ps
module adcc_properties (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 rvalid,
  input wire logic [31:0]          rdata,
  input wire logic [1:0]           rresp,
  input wire logic                 global_irq_en,
  input wire logic                 irq_vector_ack,
  input wire adcc_pkg::adcc_core_s core_ctl,
  input wire logic                 irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_global: assert property (
    !global_irq_en |=> !irq_req) else $error("irq without global enable");
  a_start_single: assert property (
    core_ctl.start |=> !core_ctl.start) else $error("start pulse too long");
  a_start_enabled: assert property (
    core_ctl.start |-> core_ctl.enable) else $error("start while off");
  a_tick_single: assert property (
    core_ctl.clk_en |=> !core_ctl.clk_en) else $error("tick faster than 2");
  // Channel must not move in the cycle after a start pulse
  a_chan_held: assert property (
    core_ctl.start |=> $stable(core_ctl.channel)) else $error("chan moved");
  a_rdata_upper: assert property (
    rvalid |-> rdata[31:8] == 24'h00_0000) else $error("rdata upper set");
  // Checked through reset itself, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> core_ctl == '0 && !irq_req) else $error("reset not quiet");
  // Converter off, so no completion can set the flag again
  a_ack_clears: assert property (
    irq_vector_ack && !core_ctl.enable |=> ##1 !irq_req)
    else $error("ack left irq");

  c_start: cover property (core_ctl.start);
  c_irq: cover property ($rose(irq_req));
  c_slverr: cover property (rvalid && rresp == 2'h2);
endmodule : adcc_properties

/* test/adcc_core_model.sv */
`timescale 1ns/1ps
module adcc_core_model (
  input  wire                  aclk,
  input  wire adcc_pkg::adcc_core_s ctl,
  output logic [9:0]           result
);
  initial result = 10'h000;
  // Unpowered core toggles so a stale value cannot pass
  always @(posedge aclk) begin
    if (ctl.enable) begin
      result <= {2'h2, ctl.channel[2:0], 5'h13};
    end else begin
      result <= ~result;
    end
  end
endmodule : adcc_core_model

/* test/adcc_top_tb_top.sv */
`timescale 1ns/1ps
module adcc_top_tb_top;
  localparam logic [11:0] RLO = 12'h1E0;
  localparam logic [11:0] RHI = 12'h1E4;
  localparam logic [11:0] CTL = 12'h1E8;
  localparam logic [11:0] TRG = 12'h1EC;
  localparam logic [11:0] MUX = 12'h1F0;
  localparam logic [1:0]  OK  = 2'h0;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [31:0] e;
    logic [1:0]  r;
  } adcc_row_s;
  logic        aclk           = 1'b0;
  logic        aresetn        = 1'b0;
  logic [11:0] awaddr         = 12'h000;
  logic        awvalid        = 1'b0;
  logic [31:0] wdata          = 32'h0000_0000;
  logic [3:0]  wstrb          = 4'hF;
  logic        wvalid         = 1'b0;
  logic        bready         = 1'b1;
  logic [11:0] araddr         = 12'h000;
  logic        arvalid        = 1'b0;
  logic        rready         = 1'b1;
  logic [6:0]  trig_in        = 7'h00;
  logic        global_irq_en  = 1'b0;
  logic        irq_vector_ack = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq_req;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [9:0]  core_result;
  adcc_pkg::adcc_core_s core_ctl;
  int          err_count      = 0;
  int          n_tests        = 0;
  int          tk             = 0;
  adcc_row_s   rows [4]       = '{
    '{TRG, 8'h05, 32'h0000_0005, OK},
    '{MUX, 8'hFF, 32'h0000_003F, OK},
    '{CTL, 8'h07, 32'h0000_0007, OK},
    '{12'h100, 8'h55, 32'h0000_0000, 2'h2}};

  adcc_top i_adcc_top (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .trig_in, .global_irq_en, .irq_vector_ack,
    .core_result, .core_ctl, .irq_req
  );
  adcc_core_model i_adcc_core_model (
    .aclk, .ctl(core_ctl), .result(core_result)
  );

  always #12.5 aclk = ~aclk;

  // Ticks since the last start pulse
  always @(posedge aclk) begin
    if (core_ctl.start) begin
      tk <= 0;
    end else if (core_ctl.clk_en) begin
      tk <= tk + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Ready and valid are read before the edge's own updates land
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      awvalid <= awvalid && !awready;
      wvalid  <= wvalid && !wready;
    end while (awvalid && !awready || wvalid && !wready);
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask : rc

  // Completion shows as the pending channel being applied
  task automatic conv(input logic [7:0] cw, input logic [7:0] mb,
                      input logic [4:0] pc, input int et, input int ep);
    int p;
    p = 0;
    wr(CTL, cw, OK);
    wr(MUX, mb, OK);
    rc(CTL, {24'h00_0000, (cw & 8'hEF) | 8'h40}, OK);
    chk({27'h0, core_ctl.channel}, {27'h0, pc});
    do @(posedge aclk); while (!core_ctl.clk_en);
    do begin
      @(posedge aclk);
      p++;
    end while (!core_ctl.clk_en);
    chk(p, ep);
    do @(posedge aclk); while (core_ctl.channel !== mb[4:0]);
    chk({31'h0, tk == et || tk == et - 1}, 32'h0000_0001);
  endtask : conv

  initial begin
    logic h;
    logic [4:0] pch;
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CTL, 32'h0000_0000, OK);
    rc(MUX, 32'h0000_0000, OK);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rc(rows[i].a, rows[i].e, rows[i].r);
    end
    wr(CTL, 8'h00, OK);
    for (int c = 0; c < 32; c++) begin
      wr(MUX, c[7:0], OK);
      // Applied channel follows the register one cycle later
      @(posedge aclk);
      chk({27'h0, core_ctl.channel}, c);
    end
    wr(MUX, 8'h03, OK);
    wr(TRG, 8'h00, OK);
    conv(8'hD0, 8'h05, 5'h03, 25, 2);
    rc(CTL, 32'h0000_0090, OK);
    rc(RLO, 32'h0000_0073, OK);
    rc(RHI, 32'h0000_0002, OK);
    wr(MUX, 8'h25, OK);
    rc(RLO, 32'h0000_00C0, OK);
    rc(RHI, 32'h0000_009C, OK);
    conv(8'hD0, 8'h26, 5'h05, 13, 2);
    rc(RHI, 32'h0000_00AC, OK);
    for (int d = 1; d < 8; d++) begin
      pch = (d > 1) ? 5'(d - 1) : 5'h06;
      conv(8'hD0 | d[7:0], 8'h20 | d[7:0], pch, 13, 2 << (d - 1));
    end
    rc(RLO, 32'h0000_00C0, OK);
    conv(8'hD0, 8'h20, 5'h07, 13, 2);
    rc(RHI, 32'h0000_00B4, OK);
    global_irq_en <= 1'b1;
    wr(CTL, 8'h88, OK);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_req}, 32'h0000_0001);
    global_irq_en <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_req}, 32'h0000_0000);
    global_irq_en <= 1'b1;
    wr(CTL, 8'h08, OK);
    chk({31'h0, irq_req}, 32'h0000_0001);
    irq_vector_ack <= 1'b1;
    @(posedge aclk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_req}, 32'h0000_0000);
    rc(CTL, 32'h0000_0008, OK);
    wr(CTL, 8'hC0, OK);
    wr(CTL, 8'h00, OK);
    rc(CTL, 32'h0000_0000, OK);
    repeat (80) @(posedge aclk);
    rc(CTL, 32'h0000_0000, OK);
    wr(TRG, 8'h01, OK);
    wr(CTL, 8'hA0, OK);
    trig_in <= 7'h01;
    h = 1'b0;
    repeat (8) @(posedge aclk) h |= core_ctl.start;
    chk({31'h0, h}, 32'h0000_0001);
    // First conversion is 25 ticks of 2 clocks each
    repeat (70) @(posedge aclk);
    trig_in <= 7'h00;
    wr(TRG, 8'h00, OK);
    h = 1'b0;
    repeat (40) @(posedge aclk) h |= core_ctl.start;
    chk({31'h0, h}, 32'h0000_0000);
    // Lane 0 disabled: register must keep its value
    wstrb <= 4'hE;
    wr(MUX, 8'h11, OK);
    wstrb <= 4'hF;
    rc(MUX, 32'h0000_0020, OK);
    // Free running: one start write, then restarts from completion
    wr(CTL, 8'hF0, OK);
    n = 0;
    repeat (100) @(posedge aclk) n += core_ctl.start;
    chk({31'h0, n >= 3}, 32'h0000_0001);
    // Reset in mid-run, while free running
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CTL, 32'h0000_0000, OK);
    rc(MUX, 32'h0000_0000, OK);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end
endmodule : adcc_top_tb_top

bind adcc_top adcc_properties i_adcc_properties (
  .aclk, .aresetn, .rvalid, .rdata, .rresp, .global_irq_en,
  .irq_vector_ack, .core_ctl, .irq_req
);
